// ---- rtl/pm_counter_pkg.sv ----
// Constants shared by the event counter register logic
`default_nettype none
package pm_counter_pkg;
  localparam logic [3:0]  CONTROL_PORT      = 4'hf;
  localparam int          NUM_SETS          = 16;
  localparam int          NUM_SLOTS         = 2;
  localparam logic [15:0] COUNTER_BASE      = 16'h0100;
  localparam logic [15:0] STATIC_LIMIT      = 16'h0020;
  localparam logic [15:0] IDX_PRODUCT       = 16'h0000;
  localparam logic [15:0] IDX_REVISION      = 16'h0001;
  localparam logic [15:0] IDX_PORT_INFO     = 16'h0002;
  localparam logic [15:0] IDX_COUNTER_CTRL  = 16'h0022;
  localparam logic [15:0] IDX_FEATURE       = 16'h0040;
  localparam int          CTRL_ENABLE_BIT   = 0;
  localparam int          CTRL_RESET_LSB    = 16;
  localparam int          FEATURE_PEC_BIT   = 3;
  localparam logic        ENABLE_RESET      = 1'b0;
  // Arbitrary neutral identity values
  localparam logic [15:0] VENDOR_CODE       = 16'h0f0f;
  localparam logic [15:0] DEVICE_CODE       = 16'h0a0a;
  localparam logic [7:0]  PRODUCT_REVISION  = 8'h01;
  localparam logic [2:0]  SPEC_SUPPORT      = 3'h7;
  localparam logic [3:0]  EXPOSED_PORTS     = 4'hf;
  localparam logic [15:0] END_OF_LIST_ID    = 16'h0000;
  localparam logic [15:0] SLOT0_ID          = 16'h000a;
  localparam logic [15:0] SLOT1_ID          = 16'h0005;
  localparam int          SLOT0_PHYS_W      = 8;
  localparam int          SLOT0_REP_W       = 16;
  localparam int          SLOT1_PHYS_W      = 20;
  localparam int          SLOT1_REP_W       = 32;
  localparam logic [7:0]  STATUS_OK         = 8'h40;
  localparam logic [7:0]  STATUS_FAIL       = 8'h41;
  localparam logic [7:0]  ERROR_NONE        = 8'h00;
  localparam logic [7:0]  ERROR_ABORT       = 8'h04;

  // Host port carries two counters, port 14 none, the rest one
  function automatic logic [1:0] slots_of(input logic [3:0] port);
    if (port == CONTROL_PORT) begin
      return 2'h2;
    end else if (port == 4'he) begin
      return 2'h0;
    end
    return 2'h1;
  endfunction

  function automatic logic [15:0] slot_id(input logic slot);
    return slot ? SLOT1_ID : SLOT0_ID;
  endfunction
endpackage
`default_nettype wire

// ---- rtl/static_cfg_if.sv ----
// Carrier between the top and the static configuration table
`default_nettype none
interface static_cfg_if;
  logic [4:0]  index;
  logic [31:0] data;
  modport requester (output index, input data);
  modport table_side (input index, output data);
endinterface
`default_nettype wire

// ---- rtl/static_cfg_table.sv ----
// Read-only static configuration registers
`default_nettype none
module static_cfg_table
  import pm_counter_pkg::*;
(
  static_cfg_if.table_side cfg
);
  // No storage at all, so no host write can ever alter it
  always_comb begin
    cfg.data = 32'h0000_0000;
    unique case ({11'h000, cfg.index})
      IDX_PRODUCT: cfg.data = {DEVICE_CODE, VENDOR_CODE};
      IDX_REVISION: cfg.data = {16'h0000, PRODUCT_REVISION,
                                4'h0, SPEC_SUPPORT, 1'b0};
      IDX_PORT_INFO: cfg.data = {28'h0000000, EXPOSED_PORTS};
      default: cfg.data = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// ---- rtl/phy_counter.sv ----
// One saturating event counter with zero-extended readout, all ones to REP_W once saturated
`default_nettype none
module phy_counter #(
  parameter int PHYS_W = 8,
  parameter int REP_W  = 16
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        event_in,
  input  wire logic        clear,
  output logic [63:0]      value
);
  typedef struct packed {
    logic [PHYS_W-1:0] count;
  } cnt_state_t;

  cnt_state_t st;
  cnt_state_t next_st;
  logic       saturated;

  assign saturated = &st.count;

  always_comb begin
    next_st = st;
    if (clear) begin
      // Event in the clearing cycle is kept
      next_st.count = (enable && event_in) ? PHYS_W'(1) : '0;
    end else if (enable && event_in && !saturated) begin
      next_st.count = st.count + PHYS_W'(1);
    end
  end

  always_comb begin
    value = 64'h0;
    if (saturated) begin
      value[REP_W-1:0] = '1;
    end else begin
      value[PHYS_W-1:0] = st.count;
    end
  end

  // Asynchronous reset comes from rst_n only; port resets, zero writes and read-clears arrive through clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/phy_event_counter_regs.sv ----
// Event counter and static register bank behind the control port
`default_nettype none
module phy_event_counter_regs
  import pm_counter_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [3:0]  cmd_port,
  input  wire logic [15:0] cmd_index,
  input  wire logic [63:0] cmd_value,
  input  wire logic        cmd_value_sel,
  input  wire logic        cmd_read_clear,
  input  wire logic        rsp_delivered,
  input  wire logic [31:0] phy_event,
  output logic             rsp_valid,
  output logic [63:0]      rsp_data,
  output logic [7:0]       rsp_status,
  output logic [7:0]       rsp_error_field,
  output logic             counting_enabled
);
  typedef struct packed {
    logic        rsp_valid;
    logic [63:0] rsp_data;
    logic [7:0]  rsp_status;
    logic [7:0]  rsp_error_field;
    logic        enable;
    logic        clr_pend;
    logic [3:0]  clr_port;
    logic        clr_slot;
  } reg_state_t;

  reg_state_t st;
  reg_state_t next_st;

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [63:0] cnt_value [NUM_SETS][NUM_SLOTS];
  logic [31:0] clr_one;
  logic [15:0] port_reset;
  logic        global_hit;
  logic        cnt_hit;
  logic [15:0] slot_off;
  logic        slot_ok;
  logic        slot;
  logic [63:0] global_data;

  static_cfg_if cfg ();

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  static_cfg_table u_static (
    .cfg (cfg)
  );

  assign cfg.index = cmd_index[4:0];

  // Command decode; everything is reached through these commands only
  assign global_hit = (cmd_port == CONTROL_PORT) &&
                      (cmd_index < COUNTER_BASE);
  assign cnt_hit    = cmd_index >= COUNTER_BASE;
  assign slot_off   = cmd_index - COUNTER_BASE;
  assign slot_ok    = cnt_hit &&
                      (slot_off < {14'h0000, slots_of(cmd_port)});
  assign slot       = slot_off[0];

  always_comb begin
    global_data = 64'h0;
    if (cmd_index < STATIC_LIMIT) begin
      global_data = {32'h0000_0000, cfg.data};
    end else if (cmd_index == IDX_COUNTER_CTRL) begin
      global_data[CTRL_ENABLE_BIT] = st.enable;
    end else if (cmd_index == IDX_FEATURE) begin
      global_data[FEATURE_PEC_BIT] = 1'b1;
    end
  end

  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    clr_one = 32'h0;
    port_reset = 16'h0;
    // Clear of a read-clear counter only once its answer is through
    if (rsp_delivered && st.clr_pend) begin
      clr_one[{st.clr_port, st.clr_slot}] = 1'b1;
      next_st.clr_pend = 1'b0;
    end
    if (cmd_valid) begin
      next_st.rsp_valid = 1'b1;
      next_st.rsp_data = 64'h0;
      next_st.rsp_status = STATUS_OK;
      next_st.rsp_error_field = ERROR_NONE;
      if (cmd_write) begin
        if (global_hit && cmd_index == IDX_COUNTER_CTRL) begin
          next_st.enable = cmd_value[CTRL_ENABLE_BIT];
          port_reset = cmd_value[CTRL_RESET_LSB +: 16];
        end else if (slot_ok) begin
          if (cmd_value == 64'h0) begin
            clr_one[{cmd_port, slot}] = 1'b1;
          end
        end else if (!global_hit) begin
          next_st.rsp_status = STATUS_FAIL;
          next_st.rsp_error_field = ERROR_ABORT;
        end
        // Other global writes hit read-only space, so no effect
      end else begin
        if (global_hit) begin
          next_st.rsp_data = global_data;
        end else if (slot_ok) begin
          if (cmd_value_sel) begin
            next_st.rsp_data = cnt_value[cmd_port][slot];
          end else begin
            next_st.rsp_data = {48'h0, slot_id(slot)};
          end
          if (cmd_read_clear) begin
            // A later read-clear replaces an undelivered one
            next_st.clr_pend = 1'b1;
            next_st.clr_port = cmd_port;
            next_st.clr_slot = slot;
          end
        end else begin
          // At or past the end marker, empty list too, and global indexes off the control port
          next_st.rsp_status = STATUS_FAIL;
          next_st.rsp_error_field = ERROR_ABORT;
        end
      end
    end
  end

  for (genvar p = 0; p < NUM_SETS; p++) begin : g_set
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      if (s < int'(slots_of(4'(p)))) begin : g_cnt
        phy_counter #(
          .PHYS_W (s == 0 ? SLOT0_PHYS_W : SLOT1_PHYS_W),
          .REP_W  (s == 0 ? SLOT0_REP_W : SLOT1_REP_W)
        ) u_cnt (
          .clock    (clock),
          .rst_n    (rst_n),
          .enable   (st.enable),
          .event_in (phy_event[p*NUM_SLOTS+s]),
          .clear    (clr_one[p*NUM_SLOTS+s] | port_reset[p]),
          .value    (cnt_value[p][s])
        );
      end else begin : g_none
        assign cnt_value[p][s] = 64'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{rsp_valid: 1'b0, rsp_data: 64'h0, rsp_status: STATUS_OK,
              rsp_error_field: ERROR_NONE, enable: ENABLE_RESET,
              clr_pend: 1'b0, clr_port: 4'h0, clr_slot: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rsp_valid        = st.rsp_valid;
  assign rsp_data         = st.rsp_data;
  assign rsp_status       = st.rsp_status;
  assign rsp_error_field  = st.rsp_error_field;
  assign counting_enabled = st.enable;
endmodule
`default_nettype wire

// ---- bench/pec_checker.sv ----
// Timing and value checks at the register bank ports
`default_nettype none
module pec_checker
  import pm_counter_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [3:0]  cmd_port,
  input wire logic [15:0] cmd_index,
  input wire logic [63:0] cmd_value,
  input wire logic        cmd_value_sel,
  input wire logic        cmd_read_clear,
  input wire logic        rsp_delivered,
  input wire logic [31:0] phy_event,
  input wire logic        rsp_valid,
  input wire logic [63:0] rsp_data,
  input wire logic [7:0]  rsp_status,
  input wire logic [7:0]  rsp_error_field,
  input wire logic        counting_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic rd = cmd_valid && !cmd_write;
  wire logic rf = rd && cmd_port == 4'hf;
  resp_follows_a: assert property (cmd_valid |-> ##1 rsp_valid)
    else $error("no response");
  no_stray_resp_a: assert property (!cmd_valid |=> !rsp_valid)
    else $error("spurious response");
  abort_pair_a: assert property (rsp_valid |->
    (rsp_status == 8'h41) == (rsp_error_field == 8'h04))
    else $error("status and error field disagree");
  empty_list_a: assert property (rd && cmd_port == 4'he &&
    cmd_index >= 16'h0100 |-> ##1 rsp_valid && rsp_status == 8'h41)
    else $error("empty list read not refused");
  product_reg_a: assert property (rf && cmd_index == 16'h0 |-> ##1
    rsp_valid && rsp_data == {32'h0, DEVICE_CODE, VENDOR_CODE})
    else $error("product register wrong");
  rsvd_zero_a: assert property (rf && cmd_index inside {[3:31]}
    |-> ##1 rsp_valid && rsp_data == 64'h0)
    else $error("reserved register not zero");
  ident_read_a: assert property (rf && cmd_index == 16'h0100 &&
    !cmd_value_sel |-> ##1 rsp_valid && rsp_data == SLOT0_ID)
    else $error("identifier read wrong");
  zero_pad_a: assert property (rd && cmd_value_sel && cmd_port < 4'he &&
    cmd_index == 16'h0100 |-> ##1 rsp_valid && rsp_data[63:16] == 0)
    else $error("upper value bits not zero");
  enable_set_a: assert property (cmd_valid && cmd_write &&
    cmd_port == 4'hf && cmd_index == 16'h0022 && cmd_value[0]
    |-> ##1 counting_enabled)
    else $error("counting not enabled");
endmodule
`default_nettype wire

// ---- bench/host_model.sv ----
// Host controller model issuing register commands
`default_nettype none
module host_model (
  input  wire logic        clock,
  input  wire logic        rsp_valid,
  input  wire logic [63:0] rsp_data,
  input  wire logic [7:0]  rsp_status,
  input  wire logic [7:0]  rsp_error_field,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [3:0]       cmd_port,
  output logic [15:0]      cmd_index,
  output logic [63:0]      cmd_value,
  output logic             cmd_value_sel,
  output logic             cmd_read_clear,
  output logic             rsp_delivered
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cmd_valid, cmd_write, cmd_port, cmd_index, cmd_value} = '0;
    {cmd_value_sel, cmd_read_clear, rsp_delivered} = '0;
  end
  task automatic xfer(input logic w, input logic [3:0] p,
    input logic [15:0] i, input logic [63:0] v, input logic s, c,
    output logic [79:0] r);
    int n;
    @(negedge clock);
    {cmd_write, cmd_port, cmd_index, cmd_value} = {w, p, i, v};
    {cmd_value_sel, cmd_read_clear, cmd_valid} = {s, c, 1'b1};
    @(negedge clock);
    cmd_valid = 1'b0;
    // Idle port, index and value fields never show a stale command; write, select and clear keep theirs
    {cmd_port, cmd_index, cmd_value} = ~{p, i, v};
    n = 0;
    while (!rsp_valid && n < 3) begin
      @(negedge clock);
      n++;
    end
    r = rsp_valid ? {rsp_status, rsp_error_field, rsp_data} : 'x;
  endtask
  task automatic deliver();
    @(negedge clock);
    rsp_delivered = 1'b1;
    @(negedge clock);
    rsp_delivered = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the event counter register bank
`default_nettype none
module tb
  import pm_counter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_b, cmd_valid, cmd_write, cmd_value_sel, en;
  logic        cmd_read_clear, rsp_delivered, rsp_valid, counting_enabled;
  logic [3:0]  cmd_port;
  logic [15:0] cmd_index;
  logic [63:0] cmd_value, rsp_data;
  logic [7:0]  rsp_status, rsp_error_field;
  logic [31:0] phy_event, m;
  logic [79:0] r;
  int          error_cnt, samples_checked, cnt[16][2];
  localparam logic [79:0] FAIL = {STATUS_FAIL, ERROR_ABORT, 64'h0};
  phy_event_counter_regs DUT (.clock, .rst_b, .cmd_valid, .cmd_write,
    .cmd_port, .cmd_index, .cmd_value, .cmd_value_sel, .cmd_read_clear,
    .rsp_delivered, .phy_event, .rsp_valid, .rsp_data, .rsp_status,
    .rsp_error_field, .counting_enabled);
  host_model host (.clock, .cmd_valid, .cmd_write, .cmd_port, .cmd_index,
    .cmd_value, .cmd_value_sel, .cmd_read_clear, .rsp_delivered,
    .rsp_valid, .rsp_data, .rsp_status, .rsp_error_field);
  function automatic int nsl(int p);
    return p == 15 ? 2 : (p == 14 ? 0 : 1);
  endfunction
  function automatic logic [79:0] ok(logic [63:0] d);
    return {STATUS_OK, ERROR_NONE, d};
  endfunction
  function automatic logic [63:0] rep(int p, int k);
    if (cnt[p][k] == (k ? 32'hfffff : 255))
      return k ? 32'hffffffff : 16'hffff;
    return 64'(cnt[p][k]);
  endfunction
  function automatic logic [63:0] sx(int i);
    case (i)
      0: return {32'h0, DEVICE_CODE, VENDOR_CODE};
      1: return {48'h0, PRODUCT_REVISION, 4'h0, SPEC_SUPPORT, 1'b0};
      2: return {60'h0, EXPOSED_PORTS};
      default: return 64'h0;
    endcase
  endfunction
  task automatic chk(input logic [79:0] s, e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmd(logic w, logic [3:0] p, logic [15:0] i,
    logic [63:0] v, logic s, c);
    host.xfer(w, p, i, v, s, c, r);
  endtask
  // Model counts the cycle the event is presented at
  task automatic run_ev(int n);
    repeat (n) begin
      @(negedge clock);
      phy_event = $urandom | 32'h1;
      for (int b = 0; b < 32; b++)
        if (en && phy_event[b] && b % 2 < nsl(b / 2) &&
            cnt[b / 2][b % 2] < (b % 2 ? 32'hfffff : 255))
          cnt[b / 2][b % 2]++;
    end
    @(negedge clock);
    phy_event = '0;
  endtask
  task automatic read_all();
    for (int p = 0; p < 16; p++)
      for (int k = 0; k < 3; k++)
        for (int s = 0; s < 2; s++) begin
          cmd(0, 4'(p), COUNTER_BASE + 16'(k), '0, 1'(s), 0);
          if (k < nsl(p))
            chk(r, ok(s ? rep(p, k) : (k ? SLOT1_ID : SLOT0_ID)));
          else chk({r[79:64], 64'h0}, FAIL);
        end
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial begin
    {rst_b, phy_event, en, error_cnt, samples_checked} = '0;
    cnt = '{default: 0};
    void'($urandom(32'h271c9a69));
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    for (int i = 0; i < 34; i++) begin
      if (i < 32) cmd(1, 4'hf, 16'(i), {$urandom, $urandom}, 0, 0);
      cmd(0, 4'hf, 16'(i), '0, 0, 0);
      chk(r, ok(i < 32 ? sx(i) : 64'h0));
    end
    cmd(0, 4'h3, IDX_PRODUCT, '0, 0, 0);
    chk({r[79:64], 64'h0}, FAIL);
    run_ev(20);
    cmd(1, 4'hf, IDX_COUNTER_CTRL, 64'h1, 0, 0);
    en = 1'b1;
    chk(80'(counting_enabled), 80'h1);
    cmd(0, 4'hf, IDX_COUNTER_CTRL, '0, 0, 0);
    chk(r, ok(64'h1));
    cmd(0, 4'hf, IDX_FEATURE, '0, 0, 0);
    chk(r, ok(64'h1 << FEATURE_PEC_BIT));
    run_ev(300);
    read_all();
    cmd(0, 4'h0, COUNTER_BASE, '0, 1, 1);
    chk(r, ok(64'hffff));
    cmd(0, 4'h0, COUNTER_BASE, '0, 1, 0);
    chk(r, ok(64'hffff));
    host.deliver();
    cnt[0][0] = 0;
    cmd(1, 4'hf, 16'h0101, '0, 0, 0);
    cnt[15][1] = 0;
    cmd(1, 4'hf, COUNTER_BASE, 64'h5, 0, 0);
    cmd(1, 4'h2, 16'h0101, '0, 0, 0);
    chk({r[79:64], 64'h0}, FAIL);
    read_all();
    run_ev(50);
    m = $urandom & 32'hffff0000 | 32'h1;
    cmd(1, 4'hf, IDX_COUNTER_CTRL, 64'(m), 0, 0);
    for (int p = 0; p < 16; p++)
      if (m[p == 15 ? 31 : 16 + p]) cnt[p] = '{0, 0};
    read_all();
    run_ev(50);
    cmd(1, 4'hf, IDX_COUNTER_CTRL, 64'hffff0001, 0, 0);
    cnt = '{default: 0};
    read_all();
    run_ev(40);
    cmd(1, 4'hf, IDX_COUNTER_CTRL, 64'h0, 0, 0);
    en = 1'b0;
    chk(80'(counting_enabled), 80'h0);
    run_ev(30);
    read_all();
    test_done();
  end
endmodule
bind phy_event_counter_regs pec_checker chk_i (.clock, .rst_b, .cmd_valid,
  .cmd_write, .cmd_port, .cmd_index, .cmd_value, .cmd_value_sel,
  .cmd_read_clear, .rsp_delivered, .phy_event, .rsp_valid, .rsp_data,
  .rsp_status, .rsp_error_field, .counting_enabled);
`default_nettype wire
